// *** adv_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface adv_if;
    logic rising_sel;
    logic adv_pulse;
    modport cond (input rising_sel, output adv_pulse);
    modport core (output rising_sel, input adv_pulse);
endinterface
`default_nettype wire

// *** advance_conditioner.sv ***
`timescale 1ns/100ps
`default_nettype none
module advance_conditioner (
    // system
    input wire logic clk,
    input wire logic rst,
    // pin
    input wire logic pin,
    // core side
    adv_if.cond      adv
);

    localparam int HW = $clog2(mcs_pkg::ADV_HOLDOFF_CYC + 1);

    logic          phase_r;
    logic [2:0]    sync_r;
    logic          level_r;
    logic [HW-1:0] hold_r;

    ////////////////////////////////////////////////////////////////////////////
    // 100 mhz sampling phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_r <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
        end
    end

    // three stage synchroniser at 100 mhz
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_r <= 3'h0;
        end else if (phase_r) begin
            sync_r <= {sync_r[1:0], pin};
        end
    end

    // accepted level once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_r <= 1'b0;
        end else if (sync_r[1] == sync_r[2]) begin
            level_r <= sync_r[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // edge select and holdoff
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            adv.adv_pulse <= 1'b0;
            hold_r        <= '0;
        end else begin
            adv.adv_pulse <= 1'b0;
            if (hold_r != '0) begin
                hold_r <= hold_r - 1'b1;
            end else if (sync_r[1] == sync_r[2] && sync_r[2] != level_r
                         && sync_r[2] == adv.rising_sel) begin
                adv.adv_pulse <= 1'b1;
                hold_r        <= HW'(mcs_pkg::ADV_HOLDOFF_CYC - 1);
            end
        end
    end

endmodule
`default_nettype wire

// *** mcs_pkg.sv ***
package mcs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [5:0] OFS_CTRL      = 6'h00;
    localparam logic [5:0] OFS_STATUS    = 6'h04;
    localparam logic [5:0] OFS_RANGE     = 6'h08;
    localparam logic [5:0] OFS_DWELL_LO  = 6'h0C;
    localparam logic [5:0] OFS_DWELL_HI  = 6'h10;
    localparam logic [5:0] OFS_PRESET_LO = 6'h14;
    localparam logic [5:0] OFS_PRESET_HI = 6'h18;
    localparam logic [5:0] OFS_SWEEP_LO  = 6'h1C;
    localparam logic [5:0] OFS_SWEEP_HI  = 6'h20;
    localparam logic [5:0] OFS_SEQ_LAST  = 6'h24;
    localparam logic [5:0] OFS_SEQ_IDX   = 6'h28;
    localparam logic [5:0] OFS_BIN_IDX   = 6'h2C;

    ////////////////////////////////////////////////////////////////////////////
    // control fields
    localparam int CTRL_RUN      = 0;
    localparam int CTRL_EXT_ADV  = 1;
    localparam int CTRL_TWO_STOP = 2;
    localparam int CTRL_SEQ_EN   = 3;
    localparam int CTRL_PRE_EN   = 4;
    localparam int CTRL_POL_LSB  = 8;
    localparam int POL_START     = 0;
    localparam int POL_STOP1     = 1;
    localparam int POL_STOP2     = 2;
    localparam int POL_ADV       = 3;

    // status fields
    localparam int STAT_ACTIVE  = 0;
    localparam int STAT_SWEEP   = 1;
    localparam int STAT_DONE    = 2;
    localparam int STAT_OVERRUN = 3;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and range limit
    localparam logic [11:0] CTRL_RESET   = 12'hF00;
    localparam logic [24:0] RANGE_RESET  = 25'h0000400;
    localparam logic [47:0] DWELL_RESET  = 48'h000000000064;
    localparam logic [47:0] PRESET_RESET = 48'h000000000001;
    localparam logic [15:0] SEQ_RESET    = 16'h0001;
    localparam logic [24:0] RANGE_MAX    = 25'h1000000;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_PS  = 5000;
    localparam int DWELL_UNIT_NS  = 10;
    localparam int DWELL_MIN1_NS  = 30;
    localparam int DWELL_MIN2_NS  = 60;
    localparam int ADV_HOLDOFF_NS = 100;
    localparam int DWELL_UNIT_CYC = (DWELL_UNIT_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [47:0] DWELL_MIN1 = 48'(DWELL_MIN1_NS / DWELL_UNIT_NS);
    localparam logic [47:0] DWELL_MIN2 = 48'(DWELL_MIN2_NS / DWELL_UNIT_NS);
    localparam int ADV_HOLDOFF_CYC =
        (ADV_HOLDOFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_SWEEP = 4'b0100,
        ST_DONE  = 4'b1000
    } seq_state_t;

endpackage

// *** multichannel_scaler_sequencer.sv ***
// Overview of operation
// - each stop event is counted into the bin given by its delay after the last start.
// - a bin lasts one dwell time, so a sweep lasts range times dwell.
// - stop inputs arrive as four sub-samples per clock so 400MHz stop rates are counted.
// - sweep length is set in single bins from one up to 16M bins.
// - at each bin end the bin counts are issued as an add into the DDR2 histogram, or dropped as overrun while the last add still waits.
// - the internal 48-bit dwell timer in 10ns units advances bins, minimum 30ns or 60ns.
// - with external advance selected each accepted advance edge steps the bin.
// - the external advance pin is synchronised on a 100MHz sampling phase.
// - advance edges closer than 100ns to the last accepted one are ignored.
// - a presettable 48-bit sweep counter counts every valid start.
// - sequencing builds spectra of a preset number of sweeps, 1 to 65536 spectra.
// - when the preset sweeps are reached the spectrum index steps and new sweeps begin.
// - software picks rising or falling as the active edge of each input.
// - switching spectra adds no gap beyond the normal rearm.
`timescale 1ns/100ps
`default_nettype none
module multichannel_scaler_sequencer #(
    parameter int BIN_CNT_W = 16
) (
    // system
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    // avalon-mm slave
    input  wire logic [5:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // front panel
    input  wire logic        START_IN,
    input  wire logic [3:0]  STOP1_SMP,
    input  wire logic [3:0]  STOP2_SMP,
    input  wire logic        EXTERNAL_BIN_ADVANCE,
    // histogram memory add port
    output logic             MEM_ADD,
    output logic      [40:0] MEM_ADDRESS,
    output logic      [31:0] MEM_INCR,
    input  wire logic        MEM_WAIT,
    // status
    output logic             ACQ_ACTIVE
);

    mcs_pkg::seq_state_t state_r;
    logic [11:0]  ctrl_r;
    logic [24:0]  range_r;
    logic [47:0]  dwell_r;
    logic [47:0]  preset_r;
    logic [47:0]  sweep_cnt_r;
    logic [15:0]  seq_last_r;
    logic [15:0]  seq_idx_r;
    logic [47:0]  spec_sweeps_r;
    logic [24:0]  bin_r;
    logic [48:0]  dwell_cnt_r;
    logic         done_r;
    logic         overrun_r;
    logic [2:0]   start_sync_r;
    logic         start_lvl_r;
    logic         start_edge;
    logic         bus_write;
    logic [47:0]  dwell_eff;
    logic [48:0]  dwell_cyc;
    logic         bin_adv;
    logic         last_bin;
    logic         sweep_end;
    logic         run_cmd;
    logic         halt_cmd;
    logic         in_sweep;
    logic [3:0]   stop_smp [2];
    logic [2:0]   stop_edges [2];
    logic [BIN_CNT_W-1:0] acc_r [2];
    logic [BIN_CNT_W-1:0] acc_sum [2];

    adv_if adv ();

    advance_conditioner u_adv (
        .clk (CLK_SYS),
        .rst (SYS_RST),
        .pin (EXTERNAL_BIN_ADVANCE),
        .adv (adv.cond)
    );

    assign adv.rising_sel = ctrl_r[mcs_pkg::CTRL_POL_LSB + mcs_pkg::POL_ADV];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // avalon handshake: waitrequest drops one cycle after request
    assign bus_write = AVS_WRITE && !AVS_WAITREQUEST;

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            AVS_READDATA <= 32'h0;
        end else if (AVS_READ && AVS_WAITREQUEST) begin
            unique case (AVS_ADDRESS)
                mcs_pkg::OFS_CTRL:      AVS_READDATA <= {20'h0, ctrl_r[11:1], ACQ_ACTIVE};
                mcs_pkg::OFS_STATUS:    AVS_READDATA <= {28'h0, overrun_r, done_r,
                                                         in_sweep, ACQ_ACTIVE};
                mcs_pkg::OFS_RANGE:     AVS_READDATA <= {7'h0, range_r};
                mcs_pkg::OFS_DWELL_LO:  AVS_READDATA <= dwell_r[31:0];
                mcs_pkg::OFS_DWELL_HI:  AVS_READDATA <= {16'h0, dwell_r[47:32]};
                mcs_pkg::OFS_PRESET_LO: AVS_READDATA <= preset_r[31:0];
                mcs_pkg::OFS_PRESET_HI: AVS_READDATA <= {16'h0, preset_r[47:32]};
                mcs_pkg::OFS_SWEEP_LO:  AVS_READDATA <= sweep_cnt_r[31:0];
                mcs_pkg::OFS_SWEEP_HI:  AVS_READDATA <= {16'h0, sweep_cnt_r[47:32]};
                mcs_pkg::OFS_SEQ_LAST:  AVS_READDATA <= {16'h0, seq_last_r};
                mcs_pkg::OFS_SEQ_IDX:   AVS_READDATA <= {16'h0, seq_idx_r};
                mcs_pkg::OFS_BIN_IDX:   AVS_READDATA <= {7'h0, bin_r};
                default:                AVS_READDATA <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_r     <= mcs_pkg::CTRL_RESET;
            range_r    <= mcs_pkg::RANGE_RESET;
            dwell_r    <= mcs_pkg::DWELL_RESET;
            preset_r   <= mcs_pkg::PRESET_RESET;
            seq_last_r <= mcs_pkg::SEQ_RESET;
        end else if (bus_write) begin
            unique case (AVS_ADDRESS)
                mcs_pkg::OFS_CTRL: begin
                    ctrl_r <= 12'(merge({20'h0, ctrl_r}, AVS_WRITEDATA, AVS_BYTEENABLE));
                end
                mcs_pkg::OFS_RANGE: begin
                    range_r <= 25'(merge({7'h0, range_r}, AVS_WRITEDATA, AVS_BYTEENABLE));
                end
                mcs_pkg::OFS_DWELL_LO: begin
                    dwell_r[31:0] <= merge(dwell_r[31:0], AVS_WRITEDATA, AVS_BYTEENABLE);
                end
                mcs_pkg::OFS_DWELL_HI: begin
                    dwell_r[47:32] <= 16'(merge({16'h0, dwell_r[47:32]}, AVS_WRITEDATA,
                                                AVS_BYTEENABLE));
                end
                mcs_pkg::OFS_PRESET_LO: begin
                    preset_r[31:0] <= merge(preset_r[31:0], AVS_WRITEDATA, AVS_BYTEENABLE);
                end
                mcs_pkg::OFS_PRESET_HI: begin
                    preset_r[47:32] <= 16'(merge({16'h0, preset_r[47:32]}, AVS_WRITEDATA,
                                                 AVS_BYTEENABLE));
                end
                mcs_pkg::OFS_SEQ_LAST: begin
                    seq_last_r <= 16'(merge({16'h0, seq_last_r}, AVS_WRITEDATA,
                                            AVS_BYTEENABLE));
                end
                default: begin
                end
            endcase
        end
    end

    assign run_cmd  = bus_write && AVS_ADDRESS == mcs_pkg::OFS_CTRL && AVS_BYTEENABLE[0]
                      && AVS_WRITEDATA[mcs_pkg::CTRL_RUN];
    assign halt_cmd = bus_write && AVS_ADDRESS == mcs_pkg::OFS_CTRL && AVS_BYTEENABLE[0]
                      && !AVS_WRITEDATA[mcs_pkg::CTRL_RUN];

    ////////////////////////////////////////////////////////////////////////////
    // start input synchroniser and edge select
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            start_sync_r <= 3'h0;
            start_lvl_r  <= 1'b0;
        end else begin
            start_sync_r <= {start_sync_r[1:0], START_IN};
            if (start_sync_r[1] == start_sync_r[2]) begin
                start_lvl_r <= start_sync_r[2];
            end
        end
    end

    assign start_edge = start_sync_r[1] == start_sync_r[2] && start_sync_r[2] != start_lvl_r
                        && start_sync_r[2] == ctrl_r[mcs_pkg::CTRL_POL_LSB
                                                     + mcs_pkg::POL_START];

    ////////////////////////////////////////////////////////////////////////////
    // stop edge counting, up to two edges per clock per channel
    assign stop_smp[0] = STOP1_SMP;
    assign stop_smp[1] = ctrl_r[mcs_pkg::CTRL_TWO_STOP] ? STOP2_SMP : 4'h0;

    generate
        for (genvar c = 0; c < 2; c++) begin : g_stop
            logic [3:0] pol_smp;
            logic       prev_r;

            assign pol_smp = ctrl_r[mcs_pkg::CTRL_POL_LSB + mcs_pkg::POL_STOP1 + c]
                             ? stop_smp[c] : ~stop_smp[c];

            always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
                if (SYS_RST) begin
                    prev_r <= 1'b0;
                end else begin
                    prev_r <= pol_smp[3];
                end
            end

            always_comb begin
                stop_edges[c] = 3'h0;
                for (int i = 0; i < 4; i++) begin
                    if (pol_smp[i] && !(i == 0 ? prev_r : pol_smp[(i + 3) % 4])) begin
                        stop_edges[c] = stop_edges[c] + 3'h1;
                    end
                end
            end

            assign acc_sum[c] = (acc_r[c] > {BIN_CNT_W{1'b1}} - BIN_CNT_W'(stop_edges[c]))
                                ? {BIN_CNT_W{1'b1}} : acc_r[c] + BIN_CNT_W'(stop_edges[c]);

            always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
                if (SYS_RST) begin
                    acc_r[c] <= '0;
                end else if (!in_sweep || bin_adv) begin
                    acc_r[c] <= '0;
                end else begin
                    acc_r[c] <= acc_sum[c];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // bin pacing
    assign in_sweep  = state_r == mcs_pkg::ST_SWEEP;
    assign dwell_eff = ctrl_r[mcs_pkg::CTRL_TWO_STOP]
                       ? (dwell_r < mcs_pkg::DWELL_MIN2 ? mcs_pkg::DWELL_MIN2 : dwell_r)
                       : (dwell_r < mcs_pkg::DWELL_MIN1 ? mcs_pkg::DWELL_MIN1 : dwell_r);
    assign dwell_cyc = 49'(dwell_eff) * 49'(mcs_pkg::DWELL_UNIT_CYC);
    assign bin_adv   = in_sweep && (ctrl_r[mcs_pkg::CTRL_EXT_ADV] ? adv.adv_pulse
                                    : dwell_cnt_r == dwell_cyc - 49'h1);
    assign last_bin  = bin_r + 25'h1 >= range_r || bin_r + 25'h1 >= mcs_pkg::RANGE_MAX;
    assign sweep_end = bin_adv && last_bin;

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            dwell_cnt_r <= 49'h0;
            bin_r       <= 25'h0;
        end else if (!in_sweep || bin_adv) begin
            dwell_cnt_r <= 49'h0;
            bin_r       <= (in_sweep && !last_bin) ? bin_r + 25'h1 : 25'h0;
        end else begin
            dwell_cnt_r <= dwell_cnt_r + 49'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // histogram add requests
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            MEM_ADD     <= 1'b0;
            MEM_ADDRESS <= 41'h0;
            MEM_INCR    <= 32'h0;
        end else if (bin_adv && !(MEM_ADD && MEM_WAIT)) begin
            MEM_ADD     <= 1'b1;
            MEM_ADDRESS <= {seq_idx_r, bin_r};
            MEM_INCR    <= {16'(acc_sum[1]), 16'(acc_sum[0])};
        end else if (!MEM_WAIT) begin
            MEM_ADD <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sweep and sequence control
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_r       <= mcs_pkg::ST_IDLE;
            spec_sweeps_r <= 48'h0;
            seq_idx_r     <= 16'h0;
            done_r        <= 1'b0;
        end else if (halt_cmd) begin
            state_r <= mcs_pkg::ST_IDLE;
        end else begin
            unique case (state_r)
                mcs_pkg::ST_IDLE, mcs_pkg::ST_DONE: begin
                    if (run_cmd) begin
                        state_r       <= mcs_pkg::ST_ARMED;
                        spec_sweeps_r <= 48'h0;
                        seq_idx_r     <= 16'h0;
                        done_r        <= 1'b0;
                    end
                end
                mcs_pkg::ST_ARMED: begin
                    if (start_edge) begin
                        state_r <= mcs_pkg::ST_SWEEP;
                    end
                end
                mcs_pkg::ST_SWEEP: begin
                    if (sweep_end) begin
                        state_r <= mcs_pkg::ST_ARMED;
                        if (ctrl_r[mcs_pkg::CTRL_SEQ_EN]) begin
                            if (spec_sweeps_r + 48'h1 >= preset_r) begin
                                spec_sweeps_r <= 48'h0;
                                if (seq_idx_r >= seq_last_r) begin
                                    state_r <= mcs_pkg::ST_DONE;
                                    done_r  <= 1'b1;
                                end else begin
                                    seq_idx_r <= seq_idx_r + 16'h1;
                                end
                            end else begin
                                spec_sweeps_r <= spec_sweeps_r + 48'h1;
                            end
                        end else if (ctrl_r[mcs_pkg::CTRL_PRE_EN]
                                     && sweep_cnt_r >= preset_r) begin
                            state_r <= mcs_pkg::ST_DONE;
                            done_r  <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // sweep counter, software preset wins over count
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            sweep_cnt_r <= 48'h0;
        end else if (bus_write && AVS_ADDRESS == mcs_pkg::OFS_SWEEP_LO) begin
            sweep_cnt_r[31:0] <= merge(sweep_cnt_r[31:0], AVS_WRITEDATA, AVS_BYTEENABLE);
        end else if (bus_write && AVS_ADDRESS == mcs_pkg::OFS_SWEEP_HI) begin
            sweep_cnt_r[47:32] <= 16'(merge({16'h0, sweep_cnt_r[47:32]}, AVS_WRITEDATA,
                                            AVS_BYTEENABLE));
        end else if (state_r == mcs_pkg::ST_ARMED && start_edge && !halt_cmd) begin
            sweep_cnt_r <= sweep_cnt_r + 48'h1;
        end
    end

    // overrun flag and activity output
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            overrun_r  <= 1'b0;
            ACQ_ACTIVE <= 1'b0;
        end else begin
            ACQ_ACTIVE <= (state_r == mcs_pkg::ST_ARMED || in_sweep) && !halt_cmd;
            if (bin_adv && MEM_ADD && MEM_WAIT) begin
                overrun_r <= 1'b1;
            end else if (run_cmd && !ACQ_ACTIVE) begin
                overrun_r <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// *** multichannel_scaler_sequencer_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module multichannel_scaler_sequencer_monitor #(
    parameter int BIN_CNT_W = 16
) (
    input wire logic        CLK_SYS,
    input wire logic        SYS_RST,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    input wire logic        MEM_ADD,
    input wire logic [40:0] MEM_ADDRESS,
    input wire logic [31:0] MEM_INCR,
    input wire logic        MEM_WAIT,
    input wire logic        ACQ_ACTIVE
);
    wire req = AVS_READ || AVS_WRITE;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    sequence s_held;
        MEM_ADD && $stable(MEM_ADDRESS) && $stable(MEM_INCR);
    endsequence
    sequence s_add_up;
        $rose(MEM_ADD);
    endsequence
    a_wait_answer: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("bus answer late");
    a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low too long");
    a_wait_idle: assert property (!req |=> AVS_WAITREQUEST)
        else $error("answer without request");
    a_rdata_hold: assert property (!(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA))
        else $error("read data changed");
    a_add_hold: assert property (MEM_ADD && MEM_WAIT |=> s_held)
        else $error("add request not held");
    a_add_release: assert property (MEM_ADD && !MEM_WAIT |=> !MEM_ADD || $changed(MEM_ADDRESS))
        else $error("add request not released");
    a_bin_spacing: assert property (s_add_up |=> (!$rose(MEM_ADD))[*5])
        else $error("bins too short");
    a_add_active: assert property (s_add_up |-> $past(ACQ_ACTIVE, 2))
        else $error("add outside sweep");
endmodule
bind multichannel_scaler_sequencer multichannel_scaler_sequencer_monitor #(
    .BIN_CNT_W(BIN_CNT_W)
) i_monitor (
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .MEM_ADD(MEM_ADD),
    .MEM_ADDRESS(MEM_ADDRESS), .MEM_INCR(MEM_INCR), .MEM_WAIT(MEM_WAIT),
    .ACQ_ACTIVE(ACQ_ACTIVE)
);
`default_nettype wire

// *** pulse_src.sv ***
`timescale 1ns/100ps
`default_nettype none
module pulse_src (
    // clock
    input  wire logic       clk,
    // discriminated pulses
    output var  logic       start,
    output var  logic [3:0] stop1,
    output var  logic [3:0] stop2,
    output var  logic       adv
);
    initial begin
        start = 1'b0;
        stop1 = 4'h0;
        stop2 = 4'h0;
        adv = 1'b0;
    end
    task automatic strobe(input bit is_adv);
        @(posedge clk);
        if (is_adv) adv <= 1'b1;
        else start <= 1'b1;
        repeat (4) @(posedge clk);
        adv <= 1'b0;
        start <= 1'b0;
    endtask
    task automatic stops(input logic [3:0] p1, input logic [3:0] p2);
        @(posedge clk);
        stop1 <= p1;
        stop2 <= p2;
    endtask
endmodule
`default_nettype wire

// *** test_multichannel_scaler_sequencer.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_multichannel_scaler_sequencer;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [5:0]  adr = 6'h00;
    logic        rde = 1'b0;
    logic        wre = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic        wrq;
    logic        st;
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic [3:0]  be = 4'hF;
    logic        adv;
    logic        madd;
    logic [40:0] maddr;
    logic [31:0] minc;
    logic        mwait = 1'b0;
    logic        act;
    logic [72:0] exp_q[$];
    int          n_mismatch = 0;
    int          n_checks = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) mwait <= ~mwait;
    multichannel_scaler_sequencer i_multichannel_scaler_sequencer (
        .CLK_SYS(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rde), .AVS_WRITE(wre),
        .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wrq), .START_IN(st), .STOP1_SMP(s1), .STOP2_SMP(s2),
        .EXTERNAL_BIN_ADVANCE(adv), .MEM_ADD(madd), .MEM_ADDRESS(maddr), .MEM_INCR(minc),
        .MEM_WAIT(mwait), .ACQ_ACTIVE(act)
    );
    pulse_src i_pulse_src (.clk(clk), .start(st), .stop1(s1), .stop2(s2), .adv(adv));
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t reg %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_add(input logic [72:0] got, input logic [72:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t add %h exp %h", $time, got, exp);
        end
    endtask
    // read compares against d, write stores d
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wre <= wr;
        rde <= ~wr;
        do @(posedge clk); while (wrq !== 1'b0);
        rde <= 1'b0;
        wre <= 1'b0;
        if (!wr) cmp_reg(rdat, d);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        if (madd === 1'b1 && mwait === 1'b0)
            cmp_add({maddr, minc}, exp_q.size() > 0 ? exp_q.pop_front() : 73'hX);
    end
    initial begin
        #100000;
        n_mismatch++;
        test_done();
    end
    initial begin
        tick(6);
        rst <= 1'b0;
        bus(1'b0, mcs_pkg::OFS_CTRL, 32'h00000F00);
        bus(1'b0, mcs_pkg::OFS_RANGE, 32'h00000400);
        bus(1'b0, mcs_pkg::OFS_DWELL_LO, 32'h00000064);
        bus(1'b1, 6'h3C, 32'hFFFFFFFF);
        bus(1'b0, 6'h3C, 32'h00000000);
        be <= 4'h2;
        bus(1'b1, mcs_pkg::OFS_DWELL_LO, 32'hFFFFFF07);
        be <= 4'hF;
        bus(1'b0, mcs_pkg::OFS_DWELL_LO, 32'h0000FF64);
        i_pulse_src.stops(4'hA, 4'h6);
        bus(1'b1, mcs_pkg::OFS_RANGE, 32'h00000003);
        bus(1'b1, mcs_pkg::OFS_DWELL_LO, 32'h00000001);
        for (int b = 0; b < 3; b++) exp_q.push_back({16'h0, 25'(b), 32'h000C0018});
        bus(1'b1, mcs_pkg::OFS_CTRL, 32'h00000B15);
        i_pulse_src.strobe(1'b0);
        while (act !== 1'b0) tick(1);
        tick(4);
        bus(1'b0, mcs_pkg::OFS_SWEEP_LO, 32'h00000001);
        bus(1'b0, mcs_pkg::OFS_STATUS, 32'h00000004);
        i_pulse_src.stops(4'h0, 4'h0);
        bus(1'b1, mcs_pkg::OFS_RANGE, 32'h00000002);
        bus(1'b1, mcs_pkg::OFS_SWEEP_LO, 32'h00000000);
        for (int s = 0; s < 4; s++) exp_q.push_back({16'(s / 2), 25'(s % 2), 32'h0});
        bus(1'b1, mcs_pkg::OFS_CTRL, 32'h00000F1B);
        for (int s = 0; s < 2; s++) begin
            i_pulse_src.strobe(1'b0);
            tick(10);
            i_pulse_src.strobe(1'b1);
            tick(4);
            i_pulse_src.strobe(1'b1);
            tick(8);
            bus(1'b0, mcs_pkg::OFS_BIN_IDX, 32'h00000001);
            tick(20);
            i_pulse_src.strobe(1'b1);
            tick(30);
        end
        bus(1'b0, mcs_pkg::OFS_STATUS, 32'h00000004);
        cmp_reg(32'(exp_q.size()), 32'h00000000);
        bus(1'b1, mcs_pkg::OFS_CTRL, 32'h00000F01);
        tick(2);
        cmp_reg(32'(act), 32'h00000001);
        bus(1'b1, mcs_pkg::OFS_CTRL, 32'h00000F00);
        bus(1'b0, mcs_pkg::OFS_STATUS, 32'h00000000);
        cmp_reg(32'(act), 32'h00000000);
        test_done();
    end
endmodule
`default_nettype wire
